// >>> verilog/stp_prescaler_top.sv
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
module stp_prescaler_top (
	input  wire logic                          mclk,
	input  wire logic                          resetn,
	input  wire logic                          hsel,
	input  wire logic [31:0]                   haddr,
	input  wire logic [1:0]                    htrans,
	input  wire logic                          hwrite,
	input  wire logic [2:0]                    hsize,
	input  wire logic [31:0]                   hwdata,
	input  wire logic                          hready,
	output logic      [31:0]                   hrdata,
	output logic                               hreadyout,
	output logic                               hresp,
	input  wire logic [stp_pkg::NUM_TIMERS-1:0] extCountPin,
	output logic      [stp_pkg::NUM_TIMERS-1:0] timerTick
);
	import stp_pkg::*;

	typedef logic [NUM_TIMERS-1:0][SEL_WIDTH-1:0] stp_sel_array_type;

	typedef struct packed {
		logic                   syncHoldMode;
		logic                   asyncPrescalerReset;
		logic                   syncPrescalerReset;
		stp_sel_array_type      tickSourceSelect;
		logic [PSC_WIDTH-1:0]   pscCount;
		logic [NUM_TIMERS-1:0]  tick;
		logic                   dataPhaseWrite;
		logic [7:0]             dataPhaseAddr;
		logic [31:0]            rdata;
		logic                   readyOut;
	} stp_state_type;

	stp_state_type         state_q;
	stp_state_type         state_d;
	logic [1:0]            rstSync_q;
	logic                  rstn;
	logic [NUM_TIMERS-1:0] riseEdge;
	logic [NUM_TIMERS-1:0] fallEdge;
	logic [NUM_TIMERS-1:0] pinLevel;
	logic [NUM_TAPS-1:0]   tapPulse;
	logic [NUM_TIMERS-1:0] nextTick;
	logic                  addrValid;
	logic                  wrSyncCtrl;
	logic                  wrTickSel;

	// Reset release through two flops
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rstSync_q <= 2'h0;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end
	assign rstn = rstSync_q[1];

	stp_pin_edge #(
		.WIDTH (NUM_TIMERS)
	) u_pin_edge (
		.mclk        (mclk),
		.rstn        (rstn),
		.extCountPin (extCountPin),
		.riseEdge    (riseEdge),
		.fallEdge    (fallEdge),
		.pinLevel    (pinLevel)
	);

	genvar k;
	genvar t;
	generate
		// One shared prescaler feeds all taps
		for (k = 0; k < NUM_TAPS; k++) begin : g_tap
			assign tapPulse[k] =
				(state_q.pscCount & TAP_MASK[k]) == TAP_MASK[k];
		end
		// Each timer picks its own source
		for (t = 0; t < NUM_TIMERS; t++) begin : g_sel
			logic [SEL_WIDTH-1:0] sel;
			logic [SEL_WIDTH-1:0] tapIdx;
			assign sel    = state_q.tickSourceSelect[t];
			assign tapIdx = sel - SEL_TAP_LO;
			always_comb begin
				unique case (sel)
					SEL_NONE:     nextTick[t] = 1'b0;
					SEL_SYSCLK:   nextTick[t] = 1'b1;
					SEL_PIN_FALL: nextTick[t] = fallEdge[t];
					SEL_PIN_RISE: nextTick[t] = riseEdge[t];
					default:      nextTick[t] =
						tapPulse[tapIdx[1:0]] & ~state_q.syncPrescalerReset;
				endcase
			end
		end
	endgenerate

	assign addrValid  = hsel & hready & htrans[1];
	assign wrSyncCtrl = state_q.dataPhaseWrite &
		(state_q.dataPhaseAddr == OFS_SYNC_CTRL);
	assign wrTickSel  = state_q.dataPhaseWrite &
		(state_q.dataPhaseAddr == OFS_TICK_SEL);

	always_comb begin
		state_d                = state_q;
		state_d.readyOut       = 1'b1;
		state_d.tick           = nextTick;
		state_d.dataPhaseWrite = addrValid & hwrite;
		state_d.dataPhaseAddr  = haddr[7:0];

		// Register reads are answered in the data phase
		if (addrValid & ~hwrite) begin
			unique case (haddr[7:0])
				OFS_SYNC_CTRL: begin
					state_d.rdata = 32'h0;
					state_d.rdata[BIT_HOLD_MODE] = state_q.syncHoldMode;
					state_d.rdata[BIT_ASYNC_RST] = state_q.asyncPrescalerReset;
					state_d.rdata[BIT_SYNC_RST]  = state_q.syncPrescalerReset;
				end
				OFS_TICK_SEL: begin
					state_d.rdata = 32'h0;
					for (int i = 0; i < NUM_TIMERS; i++) begin
						state_d.rdata[i*SEL_FIELD_STEP +: SEL_WIDTH] =
							state_q.tickSourceSelect[i];
					end
				end
				OFS_STATUS: begin
					state_d.rdata = 32'h0;
					state_d.rdata[PSC_WIDTH-1:0] = state_q.pscCount;
					state_d.rdata[STAT_PIN_LSB +: NUM_TIMERS] = pinLevel;
				end
				default: state_d.rdata = 32'h0;
			endcase
		end

		// Reset bits drop on their own unless hold mode keeps them
		if (wrSyncCtrl) begin
			state_d.syncHoldMode        = hwdata[BIT_HOLD_MODE];
			state_d.asyncPrescalerReset = hwdata[BIT_ASYNC_RST];
			state_d.syncPrescalerReset  = hwdata[BIT_SYNC_RST];
		end else if (!state_q.syncHoldMode) begin
			state_d.asyncPrescalerReset = 1'b0;
			state_d.syncPrescalerReset  = 1'b0;
		end

		// Select writes never touch the prescaler; pin sources need
		// a stable pin at the moment of the change
		if (wrTickSel) begin
			for (int i = 0; i < NUM_TIMERS; i++) begin
				state_d.tickSourceSelect[i] =
					hwdata[i*SEL_FIELD_STEP +: SEL_WIDTH];
			end
		end

		if (state_q.syncPrescalerReset) begin
			state_d.pscCount = '0;
		end else begin
			state_d.pscCount = state_q.pscCount + 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_q                     <= '0;
			state_q.syncHoldMode        <= SYNC_CTRL_RESET[BIT_HOLD_MODE];
			state_q.asyncPrescalerReset <= SYNC_CTRL_RESET[BIT_ASYNC_RST];
			state_q.syncPrescalerReset  <= SYNC_CTRL_RESET[BIT_SYNC_RST];
		end else begin
			state_q <= state_d;
		end
	end

	assign hrdata    = state_q.rdata;
	assign hreadyout = state_q.readyOut;
	assign hresp     = HRESP_OKAY;
	assign timerTick = state_q.tick;

	// Tap checks on timer 0, pin checks on timers 1 and 2
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	logic [SEL_WIDTH-1:0] sel0;
	assign sel0 = state_q.tickSourceSelect[0];
	logic [SEL_WIDTH-1:0] sel1;
	logic [SEL_WIDTH-1:0] sel2;
	assign sel1 = state_q.tickSourceSelect[1];
	assign sel2 = state_q.tickSourceSelect[2];

	sequence seq_tap8_enable;
		(sel0 != SEL_TAP_LO) ##1 (sel0 == SEL_TAP_LO);
	endsequence

	sequence seq_pin1_rise;
		(sel1 == SEL_PIN_RISE) && !extCountPin[1] ##1 extCountPin[1];
	endsequence

	sequence seq_pin2_fall;
		(sel2 == SEL_PIN_FALL) && extCountPin[2] ##1 !extCountPin[2];
	endsequence

	a_direct_clock_tick: assert property (
		(sel0 == SEL_SYSCLK) |=> timerTick[0])
		else $error("system clock source did not tick");

	a_tap_divide_8: assert property (
		(sel0 == SEL_TAP_LO) && !state_q.syncPrescalerReset &&
		(state_q.pscCount[2:0] == 3'h7) |=> timerTick[0])
		else $error("divide by 8 tap tick missing");

	a_tap_1024_only: assert property (
		(sel0 == SEL_TAP_HI) && (state_q.pscCount != 10'h3FF)
		|=> !timerTick[0])
		else $error("divide by 1024 tap ticked early");

	a_free_running: assert property (
		rstn && !state_q.syncPrescalerReset |=>
		state_q.pscCount == $past(state_q.pscCount) + 10'h001)
		else $error("prescaler did not advance");

	a_first_count: assert property (
		seq_tap8_enable ##0 !state_q.syncPrescalerReset |->
		##[1:8] (timerTick[0] || state_q.syncPrescalerReset ||
		(sel0 != SEL_TAP_LO)))
		else $error("first prescaled tick late");

	a_pin_rise_tick: assert property (
		(sel1 == SEL_PIN_RISE) |=> (timerTick[1] == $past(riseEdge[1])))
		else $error("rising edge tick mismatch");

	a_pin_fall_tick: assert property (
		(sel2 == SEL_PIN_FALL) |=> (timerTick[2] == $past(fallEdge[2])))
		else $error("falling edge tick mismatch");

	a_pin_undivided: assert property (
		(sel1 == SEL_PIN_RISE) && riseEdge[1] &&
		state_q.syncPrescalerReset |=> timerTick[1])
		else $error("pin tick was gated by prescaler");

	a_no_source_idle: assert property (
		(sel0 == SEL_NONE) |=> !timerTick[0])
		else $error("tick with no source selected");

	a_hold_retain: assert property (
		state_q.syncHoldMode && !wrSyncCtrl |=>
		$stable(state_q.syncPrescalerReset) &&
		$stable(state_q.asyncPrescalerReset))
		else $error("held reset bit changed");

	a_hold_release: assert property (
		!state_q.syncHoldMode && !wrSyncCtrl |=>
		!state_q.syncPrescalerReset && !state_q.asyncPrescalerReset)
		else $error("reset bit not cleared by hardware");

	a_reset_clears: assert property (
		state_q.syncPrescalerReset |=> (state_q.pscCount == 10'h000))
		else $error("prescaler not cleared by reset");

	a_reset_halts_tap: assert property (
		(sel0 >= SEL_TAP_LO) && (sel0 <= SEL_TAP_HI) &&
		state_q.syncPrescalerReset |=> !timerTick[0])
		else $error("tap ticked while prescaler in reset");

	a_sync_write_lands: assert property (
		wrSyncCtrl |=>
		(state_q.syncPrescalerReset == $past(hwdata[BIT_SYNC_RST])))
		else $error("sync reset write did not land");

	a_sync_self_clear: assert property (
		state_q.syncPrescalerReset && !state_q.syncHoldMode &&
		!wrSyncCtrl |=> !state_q.syncPrescalerReset)
		else $error("sync reset bit did not self clear");

	a_tap_divide_64: assert property (
		(sel0 == SEL_TAP_LO + 3'h1) && !state_q.syncPrescalerReset &&
		(state_q.pscCount[5:0] == 6'h3F) |=> timerTick[0])
		else $error("divide by 64 tap tick missing");

	a_tap_divide_256: assert property (
		(sel0 == SEL_TAP_LO + 3'h2) && !state_q.syncPrescalerReset &&
		(state_q.pscCount[7:0] == 8'hFF) |=> timerTick[0])
		else $error("divide by 256 tap tick missing");

	a_tap_8_only: assert property (
		(sel0 == SEL_TAP_LO) && (state_q.pscCount[2:0] != 3'h7)
		|=> !timerTick[0])
		else $error("divide by 8 tap ticked early");

	a_idle_timer_one: assert property (
		(sel1 == SEL_NONE) |=> !timerTick[1])
		else $error("timer one ticked with no source");

	a_idle_timer_two: assert property (
		(sel2 == SEL_NONE) |=> !timerTick[2])
		else $error("timer two ticked with no source");

	a_pin_rise_latency: assert property (
		seq_pin1_rise |-> ##[2:3] timerTick[1])
		else $error("rising pin tick outside latency window");

	a_pin_fall_latency: assert property (
		seq_pin2_fall |-> ##[2:3] timerTick[2])
		else $error("falling pin tick outside latency window");
endmodule : stp_prescaler_top

// >>> verilog/stp_pkg.sv
// Function
// - Three timers share one prescaler, own selects
// - Select one ticks timer every system clock
// - Selects two to five use prescaler taps
// - Prescaler free running, untouched by selects
// - First prescaled tick within one to N
// - Pin sampled each cycle, then edge detected
// - Select seven rising, six falling pin edges
// - Pin edge reaches counter in 2.5-3.5 cycles
// - Pin edges are never divided by prescaler
// - Hold mode keeps written prescaler reset bits
// - Clearing hold mode clears both reset bits
// - Sync reset bit resets prescaler, self clears unless hold mode is set
// - No source selected means no ticks
// - Select zero stops the timer
package stp_pkg;
	localparam int                NUM_TIMERS = 3;
	localparam int                PSC_WIDTH  = 10;
	localparam int                NUM_TAPS   = 4;
	localparam int                SEL_WIDTH  = 3;

	// Byte offsets of the register words
	localparam logic [7:0]        OFS_SYNC_CTRL  = 8'h00;
	localparam logic [7:0]        OFS_TICK_SEL   = 8'h04;
	localparam logic [7:0]        OFS_STATUS     = 8'h08;

	// Sync control bit positions
	localparam int                BIT_HOLD_MODE  = 7;
	localparam int                BIT_ASYNC_RST  = 1;
	localparam int                BIT_SYNC_RST   = 0;
	localparam logic [7:0]        SYNC_CTRL_RESET = 8'h00;

	// Tick select field spacing and status field positions
	localparam int                SEL_FIELD_STEP = 4;
	localparam int                STAT_PIN_LSB   = 16;

	// Tick source select codes
	localparam logic [2:0]        SEL_NONE     = 3'h0;
	localparam logic [2:0]        SEL_SYSCLK   = 3'h1;
	localparam logic [2:0]        SEL_TAP_LO   = 3'h2;
	localparam logic [2:0]        SEL_TAP_HI   = 3'h5;
	localparam logic [2:0]        SEL_PIN_FALL = 3'h6;
	localparam logic [2:0]        SEL_PIN_RISE = 3'h7;

	// Tap k pulses when the low bits of the prescaler are all ones
	localparam logic [NUM_TAPS-1:0][PSC_WIDTH-1:0] TAP_MASK = {
		10'h3FF, 10'h0FF, 10'h03F, 10'h007
	};

	// AHB transfer and response codes
	localparam logic [1:0]        HTRANS_IDLE   = 2'h0;
	localparam logic [1:0]        HTRANS_NONSEQ = 2'h2;
	localparam logic              HRESP_OKAY    = 1'b0;
endpackage : stp_pkg

// >>> verilog/stp_pin_edge.sv
`timescale 1ns/1ns
module stp_pin_edge #(
	parameter int WIDTH = 3
) (
	input  wire logic             mclk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] extCountPin,
	output logic      [WIDTH-1:0] riseEdge,
	output logic      [WIDTH-1:0] fallEdge,
	output logic      [WIDTH-1:0] pinLevel
);
	import stp_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] syncLevel;
		logic [WIDTH-1:0] prevLevel;
	} stp_edge_state_type;

	stp_edge_state_type state_q;
	stp_edge_state_type state_d;
	logic [WIDTH-1:0]   latchStage_q;

	// Latch stage: closes on the falling edge, as a high-transparent latch
	always_ff @(negedge mclk or negedge rstn) begin
		if (!rstn) begin
			latchStage_q <= '0;
		end else begin
			latchStage_q <= extCountPin;
		end
	end

	always_comb begin
		state_d           = state_q;
		state_d.syncLevel = latchStage_q;
		state_d.prevLevel = state_q.syncLevel;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_edge
			assign riseEdge[i] = state_q.syncLevel[i] & ~state_q.prevLevel[i];
			assign fallEdge[i] = ~state_q.syncLevel[i] & state_q.prevLevel[i];
			assign pinLevel[i] = state_q.syncLevel[i];
		end
	endgenerate
endmodule : stp_pin_edge

// >>> bench/stp_ext_source.sv
`timescale 1ns/1ns
module stp_ext_source (
	input  wire logic       mclk,
	input  wire logic [2:0] runEn,
	input  wire logic [7:0] halfCycles,
	output logic      [2:0] extCountPin
);
	logic [7:0] phase = 8'h00;
	logic [2:0] level = 3'h0;
	logic [7:0] limit;

	// Half period never shorter than two system cycles
	assign limit = (halfCycles < 8'h02) ? 8'h02 : halfCycles;
	assign extCountPin = level;

	// Stopped pins hold their level, so a select change sees no edge
	always @(posedge mclk) begin
		if (runEn == 3'h0) begin
			phase <= 8'h00;
		end else if (phase + 8'h01 >= limit) begin
			phase <= 8'h00;
			level <= level ^ runEn;
		end else begin
			phase <= phase + 8'h01;
		end
	end
endmodule : stp_ext_source

// >>> bench/shared_timer_prescaler_clock_select_tb.sv
`timescale 1ns/1ns
module shared_timer_prescaler_clock_select_tb;
	import stp_pkg::*;
	logic        mclk;
	logic        resetn;
	logic        hsel;
	logic        hwrite;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [2:0]  extCountPin;
	logic [2:0]  timerTick;
	logic [2:0]  runEn;
	logic [2:0]  pinQ = 3'h0;
	int          error_cnt;
	int          check_count;
	int          cyc;
	int          riseCyc;
	int          lat;
	int          riseCnt;
	int          fallCnt;
	int          tickCnt [3];

	stp_prescaler_top DUT (
		.mclk        (mclk),
		.resetn      (resetn),
		.hsel        (hsel),
		.haddr       (haddr),
		.htrans      (htrans),
		.hwrite      (hwrite),
		.hsize       (hsize),
		.hwdata      (hwdata),
		.hready      (hreadyout),
		.hrdata      (hrdata),
		.hreadyout   (hreadyout),
		.hresp       (hresp),
		.extCountPin (extCountPin),
		.timerTick   (timerTick)
	);

	stp_ext_source SRC (
		.mclk        (mclk),
		.runEn       (runEn),
		.halfCycles  (8'h03),
		.extCountPin (extCountPin)
	);

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		pinQ <= extCountPin;
		riseCnt <= riseCnt + int'(extCountPin[1] & ~pinQ[1]);
		fallCnt <= fallCnt + int'(~extCountPin[2] & pinQ[2]);
		if (extCountPin[1] & ~pinQ[1])
			riseCyc <= cyc;
		if (timerTick[1] === 1'b1)
			lat <= cyc - riseCyc;
		for (int i = 0; i < 3; i++)
			tickCnt[i] <= tickCnt[i] + int'(timerTick[i] === 1'b1);
	end

	task automatic report_and_stop;
		if (error_cnt == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop

	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (e !== g) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask : chk

	task automatic waitReady;
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		if (hreadyout !== 1'b1) begin
			chk("hreadyout", 1, 0);
			report_and_stop();
		end
	endtask : waitReady

	task automatic bus(logic w, logic [7:0] a, logic [31:0] d,
			output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h000000, a};
		waitReady();
		hsel <= 1'b0;
		htrans <= HTRANS_IDLE;
		hwdata <= d;
		waitReady();
		r = hrdata;
		chk("hresp", HRESP_OKAY, hresp);
	endtask : bus

	task automatic wr(logic [7:0] a, logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr

	task automatic rdChk(string s, logic [7:0] a, logic [31:0] m,
			logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h00000000, r);
		chk(s, e, r & m);
	endtask : rdChk

	// Edges until timer 0 ticks, cut short on a hang
	task automatic untilTick(output int t);
		t = 0;
		do begin
			@(posedge mclk);
			t++;
		end while (timerTick[0] !== 1'b1 && t < 1100);
		if (timerTick[0] !== 1'b1) begin
			chk("tick wait", 1, 0);
			report_and_stop();
		end
	endtask : untilTick

	task automatic regDefaults;
		rdChk("sync ctrl", OFS_SYNC_CTRL, 32'hFF, 32'h00);
		wr(8'h0C, 32'hFFFFFFFF);
		rdChk("unmapped", 8'h0C, 32'hFFFFFFFF, 32'h00);
	endtask : regDefaults

	task automatic sysClock;
		int b [3];
		wr(OFS_TICK_SEL, {29'h0, SEL_SYSCLK});
		repeat (3) @(posedge mclk);
		b = tickCnt;
		repeat (20) @(posedge mclk);
		chk("sysclk ticks", 20, tickCnt[0] - b[0]);
		chk("idle ticks", 0, tickCnt[1] + tickCnt[2] - b[1] - b[2]);
	endtask : sysClock

	task automatic taps;
		int div [4] = '{8, 64, 256, 1024};
		int t;
		for (int k = 0; k < 4; k++) begin
			wr(OFS_TICK_SEL, {29'h0, SEL_TAP_LO + 3'(k)});
			wr(OFS_SYNC_CTRL, 32'h01);
			@(posedge mclk);
			untilTick(t);
			chk("first tap", 1, t >= div[k] && t <= div[k] + 3);
			untilTick(t);
			chk("tap period", div[k], t);
			rdChk("self clear", OFS_SYNC_CTRL, 32'h01, 32'h00);
		end
	endtask : taps

	task automatic holdMode;
		int b;
		int t;
		wr(OFS_TICK_SEL, {29'h0, SEL_TAP_LO});
		wr(OFS_SYNC_CTRL, 32'h83);
		rdChk("held bits", OFS_SYNC_CTRL, 32'hFF, 32'h83);
		b = tickCnt[0];
		repeat (40) @(posedge mclk);
		chk("held ticks", b, tickCnt[0]);
		rdChk("held count", OFS_STATUS, 32'h3FF, 32'h0);
		wr(OFS_SYNC_CTRL, 32'h00);
		rdChk("released", OFS_SYNC_CTRL, 32'hFF, 32'h00);
		untilTick(t);
		chk("resume tick", 1, t <= 11);
	endtask : holdMode

	task automatic pinEdges;
		int r;
		int f;
		int b [3];
		wr(OFS_TICK_SEL, {21'h0, SEL_PIN_FALL, 1'b0, SEL_PIN_RISE, 4'h0});
		wr(OFS_SYNC_CTRL, 32'h81);
		repeat (2) @(posedge mclk);
		b = tickCnt;
		r = riseCnt;
		f = fallCnt;
		runEn <= 3'h6;
		repeat (60) @(posedge mclk);
		runEn <= 3'h0;
		repeat (8) @(posedge mclk);
		chk("rise ticks", riseCnt - r, tickCnt[1] - b[1]);
		chk("fall ticks", fallCnt - f, tickCnt[2] - b[2]);
		chk("pin latency", 1, lat >= 2 && lat <= 4);
		chk("stopped timer", 0, tickCnt[0] - b[0]);
	endtask : pinEdges

	initial begin
		resetn = 1'b0;
		hsel = 1'b0;
		htrans = HTRANS_IDLE;
		hwrite = 1'b0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		runEn = 3'h0;
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		regDefaults();
		sysClock();
		taps();
		holdMode();
		pinEdges();
		report_and_stop();
	end
endmodule : shared_timer_prescaler_clock_select_tb
